// [verilog/msdsc_pkg.sv]
// ****************************************
// shared constants and types
// ****************************************
package msdsc_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_MODULE_STOP_C = 8'h00;
  localparam logic [7:0] OFF_DEEP_STANDBY = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // ****************************************
  // module stop register c
  // ****************************************
  localparam int unsigned RAM_BANK0_STOP_BIT = 0;
  localparam int unsigned RAM_BANK1_STOP_BIT = 1;
  localparam int unsigned I2C_UNIT3_STOP_BIT = 16;
  localparam int unsigned I2C_UNIT2_STOP_BIT = 17;
  localparam int unsigned AUTO_SERIAL_BUS_STOP_BIT = 18;
  localparam int unsigned FREQ_MEASURE_STOP_BIT = 19;
  localparam int unsigned SPI_UNIT2_STOP_BIT = 22;
  localparam int unsigned SERIAL_IF11_STOP_BIT = 24;
  localparam int unsigned SERIAL_IF10_STOP_BIT = 25;
  localparam int unsigned SERIAL_IF9_STOP_BIT = 26;
  localparam int unsigned SERIAL_IF8_STOP_BIT = 27;
  localparam logic [31:0] MODULE_STOP_IMPL_MASK = 32'h0F4F_0003;
  localparam logic [31:0] MODULE_STOP_RESET = 32'h0F4F_0003;

  // ****************************************
  // deep standby control register
  // ****************************************
  localparam int unsigned POWER_CUT_LSB = 0;
  localparam int unsigned PIN_RETAIN_BIT = 6;
  localparam int unsigned DEEP_SELECT_BIT = 7;
  localparam logic [7:0] DEEP_STANDBY_IMPL_MASK = 8'hC3;
  localparam logic [7:0] DEEP_STANDBY_RESET = 8'h00;

  typedef enum logic [1:0] {
    CUT_KEEP_ALL = 2'h0,
    CUT_RAM_USB = 2'h1,
    CUT_PROHIBITED = 2'h2,
    CUT_RAM_USB_LVD = 2'h3
  } msdsc_cut_e;

  // ****************************************
  // status register
  // ****************************************
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_BAD_CUT_BIT = 4;
  localparam int unsigned STAT_WAKE_BIT = 5;
  localparam int unsigned STAT_RETAIN_BIT = 8;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTER,
    ST_DEEP,
    ST_EXIT
  } msdsc_state_e;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_FREQ_MHZ = 20;
  localparam int unsigned ENTRY_SETTLE_NS = 1000;
  localparam int unsigned EXIT_SETTLE_NS = 500;
  localparam int unsigned ENTRY_SETTLE_CYC = (ENTRY_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned EXIT_SETTLE_CYC = (EXIT_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_CNT_W = 8;

endpackage : msdsc_pkg

// [verilog/msdsc_regbus_if.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// register access between bus front end and core
// ****************************************
interface msdsc_regbus_if;
  logic wr_stb;
  logic [msdsc_pkg::ADR_W-1:0] adr;
  logic [msdsc_pkg::DAT_W-1:0] wdat;
  logic [msdsc_pkg::SEL_W-1:0] sel;
  logic [msdsc_pkg::DAT_W-1:0] rdat;

  modport front_end (
    output wr_stb,
    output adr,
    output wdat,
    output sel,
    input rdat
  );

  modport core_end (
    input wr_stb,
    input adr,
    input wdat,
    input sel,
    output rdat
  );
endinterface : msdsc_regbus_if
`default_nettype wire

// [verilog/msdsc_wb_slave.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// classic wishbone slave, one wait state
// ****************************************
module msdsc_wb_slave (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // wishbone
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [msdsc_pkg::ADR_W-1:0] wb_adr_in,
  input wire logic [msdsc_pkg::SEL_W-1:0] wb_sel_in,
  input wire logic [msdsc_pkg::DAT_W-1:0] wb_dat_in,
  output logic [msdsc_pkg::DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // core side
  msdsc_regbus_if.front_end rbus
);
  import msdsc_pkg::*;

  logic ack_q;
  logic [DAT_W-1:0] dat_q;
  wire req_new;

  // new request only while no ack is standing
  assign req_new = wb_cyc_in & wb_stb_in & ~ack_q;
  // a write lands at the edge where the master samples ack
  assign rbus.wr_stb = wb_cyc_in & wb_stb_in & wb_we_in & ack_q;
  assign rbus.adr = wb_adr_in;
  assign rbus.wdat = wb_dat_in;
  assign rbus.sel = wb_sel_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_new;
      if (req_new) begin
        dat_q <= wb_we_in ? 32'h0000_0000 : rbus.rdat;
      end
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;

endmodule : msdsc_wb_slave
`default_nettype wire

// [verilog/msdsc_top.sv]
// What this block does
// - bits 0 and 1 of module stop register c stop the first and second ram bank.
// - bits 16, 17, 18 and 19 stop the fourth i2c, third i2c, automotive bus and freq meter.
// - bit 22 stops the third spi, bits 24 to 27 stop serial interfaces 11, 10, 9 and 8.
// - power-cut code 00b keeps the first ram bank and usb resume detector powered in deep standby.
// - power-cut code 01b removes power from the first ram bank and usb resume detector.
// - code 11b also halts the voltage detector and puts power-on reset in low-power mode.
// - deep standby register holds pin retention at bit 6, deep select at bit 7, 2 to 5 reserved.
`timescale 1ns/10ps
`default_nettype none
module msdsc_top (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  // wishbone register bus
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [msdsc_pkg::ADR_W-1:0] WB_ADR_IN,
  input wire logic [msdsc_pkg::SEL_W-1:0] WB_SEL_IN,
  input wire logic [msdsc_pkg::DAT_W-1:0] WB_DAT_IN,
  output logic [msdsc_pkg::DAT_W-1:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // standby request and wake pin
  input wire logic STBY_REQ_IN,
  input wire logic WAKE_PIN_IN,
  // module clock enables
  output logic [msdsc_pkg::DAT_W-1:0] MOD_CLK_EN_OUT,
  // power controls
  output logic RAM_BANK_FIRST_PWR_OUT,
  output logic USB_RESUME_PWR_OUT,
  output logic VOLTAGE_DETECTOR_RUN_OUT,
  output logic POR_LOW_POWER_OUT,
  output logic PIN_STATE_RETAIN_OUT,
  output logic DEEP_STANDBY_OUT
);
  import msdsc_pkg::*;

  // ****************************************
  // register bus front end
  // ****************************************
  msdsc_regbus_if rbus ();

  msdsc_wb_slave u_wb_slave (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .wb_cyc_in(WB_CYC_IN),
    .wb_stb_in(WB_STB_IN),
    .wb_we_in(WB_WE_IN),
    .wb_adr_in(WB_ADR_IN),
    .wb_sel_in(WB_SEL_IN),
    .wb_dat_in(WB_DAT_IN),
    .wb_dat_out(WB_DAT_OUT),
    .wb_ack_out(WB_ACK_OUT),
    .rbus(rbus.front_end)
  );

  // ****************************************
  // declarations
  // ****************************************
  logic [31:0] module_stop_reg_c_q;
  logic [31:0] module_stop_reg_c_d;
  logic [7:0] deep_standby_ctrl_reg_q;
  logic [7:0] deep_standby_ctrl_reg_d;
  logic bad_cut_q;
  logic bad_cut_d;
  logic wake_seen_q;
  logic wake_seen_d;
  logic retain_hold_q;
  logic retain_hold_d;
  msdsc_state_e state_q;
  msdsc_state_e state_d;
  logic [SETTLE_CNT_W-1:0] settle_cnt_q;
  logic [SETTLE_CNT_W-1:0] settle_cnt_d;
  logic wake_s1_q;
  logic wake_s2_q;
  logic wake_s3_q;
  logic [31:0] clk_en_q;
  logic [31:0] clk_en_d;
  logic ram_pwr_q;
  logic usb_pwr_q;
  logic lvd_run_q;
  logic por_lp_q;
  logic deep_q;
  logic ram_pwr_d;
  logic usb_pwr_d;
  logic lvd_run_d;
  logic por_lp_d;
  logic deep_d;

  // ****************************************
  // address decode
  // ****************************************
  wire hit_stop = rbus.adr == OFF_MODULE_STOP_C;
  wire hit_deep = rbus.adr == OFF_DEEP_STANDBY;
  wire hit_stat = rbus.adr == OFF_STATUS;
  wire in_run = state_q == ST_RUN;
  // control writes only land while running
  wire wr_stop = rbus.wr_stb & hit_stop & in_run;
  wire wr_deep = rbus.wr_stb & hit_deep & rbus.sel[0] & in_run;
  wire wr_stat = rbus.wr_stb & hit_stat & rbus.sel[0];

  // ****************************************
  // module stop register c
  // ****************************************
  wire [31:0] stop_wr_val = {
    rbus.sel[3] ? rbus.wdat[31:24] : module_stop_reg_c_q[31:24],
    rbus.sel[2] ? rbus.wdat[23:16] : module_stop_reg_c_q[23:16],
    rbus.sel[1] ? rbus.wdat[15:8] : module_stop_reg_c_q[15:8],
    rbus.sel[0] ? rbus.wdat[7:0] : module_stop_reg_c_q[7:0]
  };
  // only documented stop bits are stored, the rest read zero
  wire [31:0] stop_impl_val = stop_wr_val & MODULE_STOP_IMPL_MASK;
  assign module_stop_reg_c_d = wr_stop ? stop_impl_val : module_stop_reg_c_q;

  wire ram_bank0_stop = module_stop_reg_c_q[RAM_BANK0_STOP_BIT];
  wire ram_bank1_stop = module_stop_reg_c_q[RAM_BANK1_STOP_BIT];
  wire i2c_unit3_stop = module_stop_reg_c_q[I2C_UNIT3_STOP_BIT];
  wire i2c_unit2_stop = module_stop_reg_c_q[I2C_UNIT2_STOP_BIT];
  wire auto_serial_bus_stop = module_stop_reg_c_q[AUTO_SERIAL_BUS_STOP_BIT];
  wire freq_measure_stop = module_stop_reg_c_q[FREQ_MEASURE_STOP_BIT];
  wire spi_unit2_stop = module_stop_reg_c_q[SPI_UNIT2_STOP_BIT];
  wire serial_if11_stop = module_stop_reg_c_q[SERIAL_IF11_STOP_BIT];
  wire serial_if10_stop = module_stop_reg_c_q[SERIAL_IF10_STOP_BIT];
  wire serial_if9_stop = module_stop_reg_c_q[SERIAL_IF9_STOP_BIT];
  wire serial_if8_stop = module_stop_reg_c_q[SERIAL_IF8_STOP_BIT];

  // ****************************************
  // module clock enables
  // ****************************************
  wire [31:0] stop_vec;
  assign stop_vec = {
    4'h0,
    serial_if8_stop,
    serial_if9_stop,
    serial_if10_stop,
    serial_if11_stop,
    1'b0,
    spi_unit2_stop,
    2'h0,
    freq_measure_stop,
    auto_serial_bus_stop,
    i2c_unit2_stop,
    i2c_unit3_stop,
    14'h0000,
    ram_bank1_stop,
    ram_bank0_stop
  };
  // stop bit set gates the clock; every clock is off outside run
  assign clk_en_d = in_run ? (~stop_vec & MODULE_STOP_IMPL_MASK) : 32'h0000_0000;

  // ****************************************
  // deep standby control register
  // ****************************************
  // bits 2 to 5 are reserved and held at zero
  wire [7:0] deep_wr_val = rbus.wdat[7:0] & DEEP_STANDBY_IMPL_MASK;
  assign deep_standby_ctrl_reg_d = wr_deep ? deep_wr_val : deep_standby_ctrl_reg_q;

  wire [1:0] standby_power_cut = deep_standby_ctrl_reg_q[POWER_CUT_LSB +: 2];
  wire pin_state_retain = deep_standby_ctrl_reg_q[PIN_RETAIN_BIT];
  wire deep_standby_select = deep_standby_ctrl_reg_q[DEEP_SELECT_BIT];

  // prohibited code is flagged and then handled like 01b
  wire bad_cut_wr = wr_deep & (deep_wr_val[POWER_CUT_LSB +: 2] == CUT_PROHIBITED);
  wire cut_ram_usb = standby_power_cut != CUT_KEEP_ALL;
  wire cut_lvd = standby_power_cut == CUT_RAM_USB_LVD;

  // ****************************************
  // wake pin synchroniser
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
    end else begin
      wake_s1_q <= WAKE_PIN_IN;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  wire wake_rise = wake_s2_q & ~wake_s3_q;

  // ****************************************
  // deep standby sequencer
  // ****************************************
  wire settle_done = settle_cnt_q == '0;
  wire enter_req = in_run & STBY_REQ_IN & deep_standby_select;
  wire wake_now = (state_q == ST_DEEP) & wake_rise;

  always_comb begin
    state_d = state_q;
    settle_cnt_d = settle_cnt_q;
    unique case (state_q)
      ST_RUN: begin
        if (enter_req) begin
          state_d = ST_ENTER;
          settle_cnt_d = SETTLE_CNT_W'(ENTRY_SETTLE_CYC - 1);
        end
      end
      ST_ENTER: begin
        if (settle_done) begin
          state_d = ST_DEEP;
        end else begin
          settle_cnt_d = settle_cnt_q - 1'b1;
        end
      end
      ST_DEEP: begin
        if (wake_rise) begin
          state_d = ST_EXIT;
          settle_cnt_d = SETTLE_CNT_W'(EXIT_SETTLE_CYC - 1);
        end
      end
      ST_EXIT: begin
        if (settle_done) begin
          state_d = ST_RUN;
        end else begin
          settle_cnt_d = settle_cnt_q - 1'b1;
        end
      end
    endcase
  end

  wire in_deep = state_q == ST_DEEP;

  // ****************************************
  // status flags, set wins over clear
  // ****************************************
  wire clr_bad = wr_stat & rbus.wdat[STAT_BAD_CUT_BIT];
  wire clr_wake = wr_stat & rbus.wdat[STAT_WAKE_BIT];
  assign bad_cut_d = bad_cut_wr | (bad_cut_q & ~clr_bad);
  assign wake_seen_d = wake_now | (wake_seen_q & ~clr_wake);

  // retention latches on entry and holds until software clears bit 6
  wire retain_set = (state_q == ST_ENTER) & settle_done & pin_state_retain;
  wire retain_clr = in_run & ~pin_state_retain;
  assign retain_hold_d = retain_set | (retain_hold_q & ~retain_clr);

  // ****************************************
  // power outputs
  // ****************************************
  assign ram_pwr_d = ~(in_deep & cut_ram_usb);
  assign usb_pwr_d = ~(in_deep & cut_ram_usb);
  assign lvd_run_d = ~(in_deep & cut_lvd);
  assign por_lp_d = in_deep & cut_lvd;
  assign deep_d = ~in_run;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      module_stop_reg_c_q <= MODULE_STOP_RESET;
      deep_standby_ctrl_reg_q <= DEEP_STANDBY_RESET;
      bad_cut_q <= 1'b0;
      wake_seen_q <= 1'b0;
      retain_hold_q <= 1'b0;
      state_q <= ST_RUN;
      settle_cnt_q <= '0;
    end else begin
      module_stop_reg_c_q <= module_stop_reg_c_d;
      deep_standby_ctrl_reg_q <= deep_standby_ctrl_reg_d;
      bad_cut_q <= bad_cut_d;
      wake_seen_q <= wake_seen_d;
      retain_hold_q <= retain_hold_d;
      state_q <= state_d;
      settle_cnt_q <= settle_cnt_d;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      clk_en_q <= 32'h0000_0000;
      ram_pwr_q <= 1'b1;
      usb_pwr_q <= 1'b1;
      lvd_run_q <= 1'b1;
      por_lp_q <= 1'b0;
      deep_q <= 1'b0;
    end else begin
      clk_en_q <= clk_en_d;
      ram_pwr_q <= ram_pwr_d;
      usb_pwr_q <= usb_pwr_d;
      lvd_run_q <= lvd_run_d;
      por_lp_q <= por_lp_d;
      deep_q <= deep_d;
    end
  end

  assign MOD_CLK_EN_OUT = clk_en_q;
  assign RAM_BANK_FIRST_PWR_OUT = ram_pwr_q;
  assign USB_RESUME_PWR_OUT = usb_pwr_q;
  assign VOLTAGE_DETECTOR_RUN_OUT = lvd_run_q;
  assign POR_LOW_POWER_OUT = por_lp_q;
  assign PIN_STATE_RETAIN_OUT = retain_hold_q;
  assign DEEP_STANDBY_OUT = deep_q;

  // ****************************************
  // read data
  // ****************************************
  logic [1:0] state_code;
  always_comb begin
    unique case (state_q)
      ST_RUN: state_code = 2'h0;
      ST_ENTER: state_code = 2'h1;
      ST_DEEP: state_code = 2'h2;
      ST_EXIT: state_code = 2'h3;
    endcase
  end

  wire [31:0] stat_val = {
    23'h000000,
    retain_hold_q,
    2'h0,
    wake_seen_q,
    bad_cut_q,
    2'h0,
    state_code
  };

  assign rbus.rdat = hit_stop ? module_stop_reg_c_q :
                     hit_deep ? {24'h000000, deep_standby_ctrl_reg_q} :
                     hit_stat ? stat_val : 32'h0000_0000;

endmodule : msdsc_top
`default_nettype wire

// [tb/msdsc_checker.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// port checker for the standby block
// ****************************************
module msdsc_checker (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic [31:0] MOD_CLK_EN_OUT,
  input wire logic RAM_BANK_FIRST_PWR_OUT,
  input wire logic USB_RESUME_PWR_OUT,
  input wire logic VOLTAGE_DETECTOR_RUN_OUT,
  input wire logic POR_LOW_POWER_OUT,
  input wire logic DEEP_STANDBY_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  ack_one_wait_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  write_data_zero_a: assert property (WB_ACK_OUT && WB_WE_IN |-> WB_DAT_OUT == 32'h0)
    else $error("read data not zero on write");
  clk_map_a: assert property ((MOD_CLK_EN_OUT & ~32'h0F4F_0003) == 32'h0)
    else $error("clock enable outside mapped bits");
  deep_clk_off_a: assert property (DEEP_STANDBY_OUT |-> MOD_CLK_EN_OUT == 32'h0)
    else $error("module clock running in standby");
  run_powered_a: assert property (!DEEP_STANDBY_OUT |-> RAM_BANK_FIRST_PWR_OUT)
    else $error("ram unpowered while running");
  ram_usb_pair_a: assert property (RAM_BANK_FIRST_PWR_OUT == USB_RESUME_PWR_OUT)
    else $error("ram and usb power differ");
  full_cut_a: assert property (POR_LOW_POWER_OUT |->
    !VOLTAGE_DETECTOR_RUN_OUT && !RAM_BANK_FIRST_PWR_OUT)
    else $error("low power reset without full cut");
  entry_settle_a: assert property ($rose(DEEP_STANDBY_OUT) |-> RAM_BANK_FIRST_PWR_OUT [*8])
    else $error("power cut during entry settle");
endmodule : msdsc_checker
bind msdsc_top msdsc_checker u_msdsc_checker (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
  .WB_WE_IN(WB_WE_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
  .MOD_CLK_EN_OUT(MOD_CLK_EN_OUT), .RAM_BANK_FIRST_PWR_OUT(RAM_BANK_FIRST_PWR_OUT),
  .USB_RESUME_PWR_OUT(USB_RESUME_PWR_OUT), .VOLTAGE_DETECTOR_RUN_OUT(VOLTAGE_DETECTOR_RUN_OUT),
  .POR_LOW_POWER_OUT(POR_LOW_POWER_OUT), .DEEP_STANDBY_OUT(DEEP_STANDBY_OUT));
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// bench for module stop and deep standby
// ****************************************
module testbench;
  import msdsc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0, wake = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, clk_en, r;
  logic ack, ram, usb, voltage_detector, por, ret, deep;
  wire [5:0] pw = {deep, ram, usb, voltage_detector, por, ret};
  logic [31:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  int unsigned bits[11] = '{0, 1, 16, 17, 18, 19, 22, 24, 25, 26, 27};
  logic [1:0] codes[3] = '{2'h0, 2'h1, 2'h3}; // code 10b never written
  always #25 clk = ~clk;
  msdsc_top u_msdsc_top (
    .CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .STBY_REQ_IN(req), .WAKE_PIN_IN(wake), .MOD_CLK_EN_OUT(clk_en),
    .RAM_BANK_FIRST_PWR_OUT(ram), .USB_RESUME_PWR_OUT(usb), .VOLTAGE_DETECTOR_RUN_OUT(voltage_detector),
    .POR_LOW_POWER_OUT(por), .PIN_STATE_RETAIN_OUT(ret), .DEEP_STANDBY_OUT(deep));
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t output %h expected %h", $time, got, exp);
    end
  endtask : chk_pin
  // classic single cycle, expected read data noted first
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 20) begin
      err_total++;
      $display("ERROR %0t no ack", $time);
      print_verdict();
    end
  endtask : wb
  task automatic pulse_req();
    @(posedge clk) req <= 1'b1;
    @(posedge clk) req <= 1'b0;
  endtask : pulse_req
  // ****************************************
  // answer monitor
  // ****************************************
  always @(posedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("ERROR %0t ack without request", $time);
      end else chk_rd(rdat, exp_q.pop_front());
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(92130));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_pin(clk_en, 32'h0);
    chk_pin(32'(pw), 32'(6'b011100));
    wb(1'b0, OFF_MODULE_STOP_C, 32'h0, 4'hF, 32'h0F4F_0003);
    wb(1'b0, OFF_DEEP_STANDBY, 32'h0, 4'hF, 32'h0);
    foreach (bits[i]) begin
      wb(1'b1, OFF_MODULE_STOP_C, MODULE_STOP_IMPL_MASK & ~(32'h1 << bits[i]), 4'hF, 32'h0);
      repeat (2) @(posedge clk);
      chk_pin(clk_en, 32'h1 << bits[i]);
    end
    wb(1'b1, OFF_MODULE_STOP_C, 32'h0, 4'h1, 32'h0);
    wb(1'b0, OFF_MODULE_STOP_C, 32'h0, 4'hF, 32'h074F_0000);
    r = $urandom;
    wb(1'b1, OFF_MODULE_STOP_C, r, 4'hF, 32'h0);
    wb(1'b0, OFF_MODULE_STOP_C, 32'h0, 4'hF, r & 32'h0F4F_0003);
    repeat (2) @(posedge clk);
    chk_pin(clk_en, ~r & 32'h0F4F_0003);
    wb(1'b1, OFF_DEEP_STANDBY, 32'hFFFF_FFFF, 4'hF, 32'h0);
    wb(1'b0, OFF_DEEP_STANDBY, 32'h0, 4'hF, 32'h0000_00C3);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF, 32'h0);
    wb(1'b0, 8'h0C, 32'h0, 4'hF, 32'h0);
    // request without deep select stays running
    wb(1'b1, OFF_DEEP_STANDBY, 32'h41, 4'hF, 32'h0);
    pulse_req();
    repeat (30) @(posedge clk);
    chk_pin(32'(pw), 32'(6'b011100));
    foreach (codes[k]) begin
      wb(1'b1, OFF_MODULE_STOP_C, 32'h0, 4'hF, 32'h0);
      wb(1'b1, OFF_DEEP_STANDBY, {24'h0, 6'h30, codes[k]}, 4'hF, 32'h0);
      pulse_req();
      repeat (30) @(posedge clk);
      chk_pin(clk_en, 32'h0);
      chk_pin(32'(pw), 32'({1'b1, {2{codes[k] == 2'h0}}, codes[k] != 2'h3,
        codes[k] == 2'h3, 1'b1}));
      wb(1'b1, OFF_MODULE_STOP_C, MODULE_STOP_IMPL_MASK, 4'hF, 32'h0);
      @(posedge clk) wake <= 1'b1;
      repeat (20) @(posedge clk);
      wake <= 1'b0;
      chk_pin(32'(pw), 32'(6'b011101));
      chk_pin(clk_en, MODULE_STOP_IMPL_MASK);
    end
    wb(1'b0, OFF_STATUS, 32'h0, 4'hF, 32'h0000_0120);
    wb(1'b1, OFF_STATUS, 32'h0000_0030, 4'hF, 32'h0);
    wb(1'b1, OFF_DEEP_STANDBY, 32'h0, 4'hF, 32'h0);
    repeat (3) @(posedge clk);
    chk_pin(32'(pw), 32'(6'b011100));
    wb(1'b0, OFF_STATUS, 32'h0, 4'hF, 32'h0);
    // reset in mid-run must stop every module again
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk_pin(clk_en, 32'h0);
    chk_pin(32'(pw), 32'(6'b011100));
    wb(1'b0, OFF_MODULE_STOP_C, 32'h0, 4'hF, MODULE_STOP_RESET);
    @(posedge clk);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
